//--- smm_ram_control_access_control.sv
// smm ram control register, lock logic and host cycle routing
`timescale 1ns/10ps
`include "smm_ram_control_defs.svh"
module smm_ram_control_access_control
  import smm_ram_control_pkg::*;
(
  // clock and power-on reset
  input  wire logic        clk,
  input  wire logic        reset,
  // configuration access
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_write,
  input  wire logic        cfg_read,
  input  wire logic [7:0]  cfg_wdata,
  output logic [7:0]       cfg_rdata,
  // memory top from the row boundary logic
  input  wire logic [31:0] memory_top,
  // host cycle
  input  wire logic        cyc_valid,
  input  wire logic [31:0] cyc_addr,
  input  wire logic        cyc_smm,
  input  wire logic        cyc_code,
  input  wire logic        cyc_writeback,
  // routing result
  output logic             route_valid,
  output dest_t            route_dest,
  output logic [31:0]      route_addr,
  // register contents
  output logic [7:0]       dram_row_population,
  output logic             smm_space_lock
);
  logic [7:0]  smm_ram_control;
  sel2_t       graphics_memory_select;
  sel2_t       upper_range_select;
  sel2_t       legacy_segment_select;
  logic        extended_smm_ram_control_violation_flag;
  logic        extended_range_error;
  dest_t       next_dest;
  logic [31:0] next_addr;
  logic        wr_smm_ram_control;
  logic        wr_row_pop;

  assign wr_smm_ram_control   = cfg_write && (cfg_addr == `SMM_RAM_CONTROL_OFFSET);
  assign wr_row_pop = cfg_write && (cfg_addr == `ROW_POP_OFFSET);

  assign smm_ram_control = {graphics_memory_select, upper_range_select,
                            legacy_segment_select, smm_space_lock,
                            extended_smm_ram_control_violation_flag};

  // lock only rises by write; only power-on reset brings it down
  always_ff @(posedge clk) begin
    if (reset) begin
      smm_space_lock <= 1'b0;
    end else if (wr_smm_ram_control && cfg_wdata[`LOCK_BIT]) begin
      smm_space_lock <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      graphics_memory_select <= sel2_t'(`SMM_RAM_CONTROL_RESET >> `GFX_SEL_LSB);
      upper_range_select     <= sel2_t'(`SMM_RAM_CONTROL_RESET >> `UPPER_SEL_LSB);
    end else if (wr_smm_ram_control && !smm_space_lock) begin
      graphics_memory_select <= cfg_wdata[`GFX_SEL_MSB:`GFX_SEL_LSB];
      upper_range_select     <= cfg_wdata[`UPPER_SEL_MSB:`UPPER_SEL_LSB];
    end
  end

  // a locked bit 2 may still move while bit 3 is one, so 11 can drop to 10
  always_ff @(posedge clk) begin
    if (reset) begin
      legacy_segment_select <= sel2_t'(`SMM_RAM_CONTROL_RESET >> `LOWER_SEL_LO);
    end else if (wr_smm_ram_control) begin
      if (!smm_space_lock) begin
        legacy_segment_select <= cfg_wdata[`LOWER_SEL_HI:`LOWER_SEL_LO];
      end else if (legacy_segment_select[1]) begin
        legacy_segment_select[0] <= cfg_wdata[`LOWER_SEL_LO];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dram_row_population <= `ROW_POP_RESET;
    end else if (wr_row_pop && !smm_space_lock) begin
      dram_row_population <= cfg_wdata;
    end
  end

  // a violation in the same cycle as a clearing write keeps the flag set
  always_ff @(posedge clk) begin
    if (reset) begin
      extended_smm_ram_control_violation_flag <= 1'b0;
    end else if (cyc_valid && extended_range_error && !cyc_writeback) begin
      extended_smm_ram_control_violation_flag <= 1'b1;
    end else if (wr_smm_ram_control && cfg_wdata[`ERR_BIT]) begin
      extended_smm_ram_control_violation_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_read) begin
      unique case (cfg_addr)
        `SMM_RAM_CONTROL_OFFSET: cfg_rdata <= smm_ram_control;
        `ROW_POP_OFFSET: cfg_rdata <= dram_row_population;
        default:       cfg_rdata <= 8'h00;
      endcase
    end
  end

  // the host qualifies each cycle with smm and code indications
  smm_ram_control_range_decode decode (
    .upper_range_select     (upper_range_select),
    .legacy_segment_select  (legacy_segment_select),
    .graphics_memory_select (graphics_memory_select),
    .memory_top             (memory_top),
    .addr                   (cyc_addr),
    .smm_active             (cyc_smm),
    .code_read              (cyc_code),
    .dest                   (next_dest),
    .dram_addr              (next_addr),
    .extended_range_error   (extended_range_error)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      route_valid <= 1'b0;
      route_dest  <= DEST_DRAM;
      route_addr  <= 32'h00000000;
    end else begin
      route_valid <= cyc_valid;
      if (cyc_valid) begin
        route_dest <= next_dest;
        route_addr <= next_addr;
      end
    end
  end
endmodule

//--- smm_ram_control_defs.svh
// register layout, reset values and address constants for smm ram control
`ifndef SMM_RAM_CONTROL_DEFS_SVH
`define SMM_RAM_CONTROL_DEFS_SVH
`define SMM_RAM_CONTROL_OFFSET        8'h70
`define SMM_RAM_CONTROL_RESET         8'h00
`define ROW_POP_OFFSET      8'h60
`define ROW_POP_RESET       8'h00
`define GFX_SEL_MSB         7
`define GFX_SEL_LSB         6
`define UPPER_SEL_MSB       5
`define UPPER_SEL_LSB       4
`define LOWER_SEL_HI        3
`define LOWER_SEL_LO        2
`define LOCK_BIT            1
`define ERR_BIT             0
`define HIGH_WIN_BASE       32'hfeea0000
`define HIGH_WIN_LAST       32'hfeebffff
`define AB_SEG_BASE         32'h000a0000
`define AB_SEG_LAST         32'h000bffff
`define HIGH_TO_AB_OFFSET   32'hfee00000
`define TOP_SEG_SIZE_512K   32'h00080000
`define TOP_SEG_SIZE_1M     32'h00100000
`endif

//--- smm_ram_control_pkg.sv
// types shared by the smm ram decode files
package smm_ram_control_pkg;
  typedef enum logic [2:0] {
    DEST_DRAM     = 3'b001,
    DEST_GRAPHICS = 3'b010,
    DEST_HUB      = 3'b100
  } dest_t;
  typedef logic [1:0] sel2_t;
endpackage

//--- smm_ram_control_range_decode.sv
// combinational routing decision for one host cycle
`timescale 1ns/10ps
`include "smm_ram_control_defs.svh"
module smm_ram_control_range_decode
  import smm_ram_control_pkg::*;
(
  // register fields
  input  wire sel2_t       upper_range_select,
  input  wire sel2_t       legacy_segment_select,
  input  wire sel2_t       graphics_memory_select,
  input  wire logic [31:0] memory_top,
  // host cycle
  input  wire logic [31:0] addr,
  input  wire logic        smm_active,
  input  wire logic        code_read,
  // result
  output dest_t            dest,
  output logic [31:0]      dram_addr,
  output logic             extended_range_error
);
  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  logic        top_en;
  logic [31:0] top_size;
  logic        high_en;
  logic        hit_top;
  logic        hit_high;
  logic        hit_ab;
  logic        ab_dram;
  dest_t       legacy_dest;

  always_comb begin
    top_en   = upper_range_select[1];
    top_size = upper_range_select[0] ? `TOP_SEG_SIZE_1M
                                     : `TOP_SEG_SIZE_512K;
    high_en  = (upper_range_select != 2'b00)
               && (legacy_segment_select == 2'b00);
    hit_top  = top_en && (addr >= memory_top - top_size)
               && (addr < memory_top);
    hit_high = high_en && in_range(addr, `HIGH_WIN_BASE,
                                   `HIGH_WIN_LAST);
    hit_ab   = in_range(addr, `AB_SEG_BASE, `AB_SEG_LAST);
    // a non-zero graphics select claims the vga range internally
    legacy_dest = (graphics_memory_select != 2'b00) ? DEST_GRAPHICS
                                                    : DEST_HUB;
    unique case (legacy_segment_select)
      2'b00: ab_dram = 1'b0;
      2'b01: ab_dram = 1'b1;
      2'b10: ab_dram = smm_active && code_read;
      2'b11: ab_dram = smm_active;
    endcase
    extended_range_error = (hit_top || hit_high) && !smm_active;
    dram_addr = addr;
    if (hit_top || hit_high) begin
      dest = smm_active ? DEST_DRAM : DEST_HUB;
      if (hit_high) begin
        dram_addr = addr - `HIGH_TO_AB_OFFSET;
      end
    end else if (hit_ab) begin
      dest = ab_dram ? DEST_DRAM : legacy_dest;
    end else begin
      dest = DEST_DRAM;
    end
  end
endmodule

//--- host_bus_model.sv
// host processor bus model issuing smm and non-smm cycles
`timescale 1ns/10ps
module host_bus_model (
  // clock
  input  wire logic        clk,
  // host cycle
  output logic             cyc_valid,
  output logic [31:0]      cyc_addr,
  output logic             cyc_smm,
  output logic             cyc_code,
  output logic             cyc_writeback
);
  initial cyc_valid = 1'b0;
  initial cyc_addr = 32'h00000000;
  initial {cyc_smm, cyc_code, cyc_writeback} = 3'h0;
  // flags travel with every cycle; f is {smm, code, writeback}
  task automatic issue(input logic [31:0] a, input logic [2:0] f);
    @(posedge clk) #1;
    cyc_valid = 1'b1;
    cyc_addr = a;
    {cyc_smm, cyc_code, cyc_writeback} = f;
    @(posedge clk) #1;
    cyc_valid = 1'b0;
    // released lines do not keep the last value
    cyc_addr = ~a;
    {cyc_smm, cyc_code, cyc_writeback} = ~f;
  endtask
endmodule

//--- smm_ram_control_access_control_chk.sv
// port checker for the smm ram access control block
`timescale 1ns/10ps
module smm_ram_control_access_control_chk
  import smm_ram_control_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  cfg_addr,
  input wire logic        cfg_write,
  input wire logic        cfg_read,
  input wire logic [7:0]  cfg_wdata,
  input wire logic [7:0]  cfg_rdata,
  input wire logic        cyc_valid,
  input wire logic [31:0] cyc_addr,
  input wire logic        cyc_smm,
  input wire logic        route_valid,
  input wire dest_t       route_dest,
  input wire logic [31:0] route_addr,
  input wire logic [7:0]  dram_row_population,
  input wire logic        smm_space_lock
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  chk_route_follows: assert property (cyc_valid |=> route_valid)
    else $error("no route after host cycle");
  chk_dest_onehot: assert property (route_valid |-> $onehot(route_dest))
    else $error("route destination not one-hot");
  chk_lock_sets: assert property (cfg_write && cfg_addr == 8'h70
    && cfg_wdata[1] |=> smm_space_lock) else $error("lock not set");
  chk_lock_holds: assert property (smm_space_lock |=> smm_space_lock)
    else $error("lock cleared without reset");
  chk_row_write: assert property (cfg_write && cfg_addr == 8'h60
    && !smm_space_lock |=> dram_row_population == $past(cfg_wdata))
    else $error("row population write lost");
  chk_row_frozen: assert property (smm_space_lock
    |=> $stable(dram_row_population)) else $error("locked row reg moved");
  chk_row_readback: assert property (cfg_read && cfg_addr == 8'h60
    |=> cfg_rdata == $past(dram_row_population)) else $error("bad readback");
  // the window may be off, then the address passes through unchanged
  chk_high_remap: assert property (cyc_valid && cyc_smm
    && cyc_addr[31:17] == 15'h7f75 |=> route_dest != DEST_DRAM
    || route_addr == $past(cyc_addr) - 32'hfee00000
    || route_addr == $past(cyc_addr))
    else $error("high window not remapped");
  cov_hub: cover property (route_valid && route_dest == DEST_HUB);
  cov_locked_write: cover property (smm_space_lock && cfg_write);
  cov_non_smm: cover property (cyc_valid && !cyc_smm);
endmodule
bind smm_ram_control_access_control smm_ram_control_access_control_chk u_chk (.clk, .reset,
  .cfg_addr, .cfg_write, .cfg_read, .cfg_wdata, .cfg_rdata, .cyc_valid,
  .cyc_addr, .cyc_smm, .route_valid, .route_dest, .route_addr,
  .dram_row_population, .smm_space_lock);

//--- smm_ram_control_access_control_bench.sv
// self-checking bench for the smm ram access control block
`timescale 1ns/10ps
module smm_ram_control_access_control_bench;
  import smm_ram_control_pkg::*;
  logic        clk = 0, reset = 1, cfg_write = 0, cfg_read = 0;
  logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, v;
  logic [7:0]  dram_row_population;
  logic [31:0] memory_top = 32'h01000000, cyc_addr, route_addr;
  logic        cyc_valid, cyc_smm, cyc_code, cyc_writeback;
  logic        route_valid, smm_space_lock;
  dest_t       route_dest;
  int          num_errors = 0, comparisons = 0;
  always #5 clk = ~clk;
  smm_ram_control_access_control u_dut (.clk, .reset, .cfg_addr, .cfg_write,
    .cfg_read, .cfg_wdata, .cfg_rdata, .memory_top, .cyc_valid, .cyc_addr,
    .cyc_smm, .cyc_code, .cyc_writeback, .route_valid, .route_dest,
    .route_addr, .dram_row_population, .smm_space_lock);
  host_bus_model u_host (.clk, .cyc_valid, .cyc_addr, .cyc_smm, .cyc_code,
    .cyc_writeback);
  task automatic check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) #1;
    {cfg_write, cfg_addr, cfg_wdata} = {1'b1, a, d};
    @(posedge clk) #1;
    cfg_write = 0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk) #1;
    {cfg_read, cfg_addr} = {1'b1, a};
    @(posedge clk) #1;
    cfg_read = 0;
    check(cfg_rdata, exp);
  endtask
  task automatic go(input logic [31:0] a, input logic [2:0] f, dest_t d);
    u_host.issue(a, f);
    check({route_valid, route_dest}, {1'b1, d});
  endtask
  task automatic t_lower();
    logic [2:0] f;
    for (int l = 0; l < 4; l++) begin
      wr(8'h70, 8'(l << 2));
      for (int k = 0; k < 3; k++) begin
        f = (k == 0) ? 3'b000 : (k == 1) ? 3'b100 : 3'b110;
        // graphics off, so anything kept from dram goes to the hub
        go(32'h000a8000, f, (l == 1 || (l == 3 && k > 0) || (l == 2 && k == 2))
          ? DEST_DRAM : DEST_HUB);
      end
    end
    wr(8'h70, 8'h8c);
    go(32'h000a8000, 3'b000, DEST_GRAPHICS);
    $display("lower select test done");
  endtask
  task automatic t_upper();
    wr(8'h70, 8'h20);
    go(32'h00f80000, 3'b100, DEST_DRAM);
    go(32'h00f80000, 3'b001, DEST_HUB);
    rd(8'h70, 8'h20);
    go(32'h00f7fffc, 3'b000, DEST_DRAM);
    go(32'h00f80000, 3'b000, DEST_HUB);
    rd(8'h70, 8'h21);
    wr(8'h70, 8'h20);
    rd(8'h70, 8'h21);
    wr(8'h70, 8'h21);
    rd(8'h70, 8'h20);
    wr(8'h70, 8'h10);
    go(32'hfeea0000, 3'b100, DEST_DRAM);
    check(route_addr, 32'h000a0000);
    go(32'h00f80000, 3'b000, DEST_DRAM);
    go(32'hfeebfffc, 3'b000, DEST_HUB);
    wr(8'h70, 8'h15);
    go(32'hfeea0000, 3'b000, DEST_DRAM);
    rd(8'h70, 8'h14);
    $display("upper select test done");
  endtask
  task automatic t_lock();
    wr(8'h60, 8'h5a);
    rd(8'h60, 8'h5a);
    check(dram_row_population, 8'h5a);
    wr(8'h70, 8'hae);
    check(smm_space_lock, 1'b1);
    wr(8'h70, 8'h40);
    rd(8'h70, 8'haa);
    wr(8'h60, 8'h00);
    rd(8'h60, 8'h5a);
    @(posedge clk) #1 reset = 1;
    @(posedge clk) #1 reset = 0;
    rd(8'h70, 8'h00);
    wr(8'h70, 8'h02);
    wr(8'h70, 8'h04);
    rd(8'h70, 8'h02);
    $display("lock test done");
  endtask
  task automatic summarize();
    $display("%0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 reset = 0;
    rd(8'h33, 8'h00);
    t_lower();
    t_upper();
    t_lock();
    summarize();
  end
endmodule
